// File: sap_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sap_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem_r[rd_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      cnt_nxt = cnt_r;
      if (push) begin
         wr_nxt = (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
         rd_nxt = (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage needs no reset; validity is tracked by the count
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_r[wr_r] <= in_data_i;
      end
   end
endmodule
`default_nettype wire

// File: sap_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sap_partner (
   input wire logic sdo_i,
   output logic frame_o,
   output logic bit_o,
   output logic [3:0] sdata_o
);
   initial begin
      frame_o = 1'b1;
      bit_o = 1'b1;
      sdata_o = 4'h0;
   end

   // One half frame of 32 bit clocks: data moves on the fall, the rise is the sampling point.
   // Outside the word window the lines flip, so stale bits can never pass for data.
   task automatic send_half(input logic [23:0] w [4], input logic chan, input int start,
                            output logic [23:0] cap);
      int p;
      cap = '0;
      for (p = 0; p < 32; p++) begin
         bit_o = 1'b0;
         if (p == 0) frame_o = chan;
         for (int i = 0; i < 4; i++) begin
            sdata_o[i] = (p >= start && p < start + 24) ? w[i][23 - (p - start)] : ~sdata_o[i];
         end
         #200;
         bit_o = 1'b1;
         // Late in the bit: the device output moves a few master clocks after the fall
         #190;
         if (p >= start && p < start + 24) cap[23 - (p - start)] = sdo_i;
         #10;
      end
   endtask
endmodule
`default_nettype wire

// File: sap_pkg.sv
package sap_pkg;
   localparam int SAP_WORD_W = 24;
   localparam int SAP_FIFO_DEPTH = 8;
   localparam int SAP_INPUTS = 4;
   localparam int SAP_SYNC_STAGES = 2;
   localparam int SAP_STRAP_SAMPLES = 4;

   // Port control register field positions
   localparam int SAP_SYNC_FMT_LSB = 2;
   localparam int SAP_SYNC_FMT_MSB = 3;
   localparam int SAP_CONV_FMT_LSB = 9;
   localparam int SAP_CONV_FMT_MSB = 12;

   // Clock pair indices and reset defaults
   localparam logic [1:0] SAP_PAIR_SYNC_DEF = 2'h1;
   localparam logic [1:0] SAP_PAIR_SIX_DEF = 2'h0;
   localparam logic [1:0] SAP_PAIR_ST_DEF = 2'h2;
   localparam logic [1:0] SAP_PAIR_BAD = 2'h3;

   // Two-channel serial formats
   localparam logic [1:0] SAP_FMT_I2S = 2'h0;
   localparam logic [1:0] SAP_FMT_LJ = 2'h1;
   localparam logic [1:0] SAP_FMT_RJ = 2'h2;
   localparam logic [5:0] SAP_START_I2S = 6'h01;
   localparam logic [5:0] SAP_START_LJ = 6'h00;
   localparam logic [5:0] SAP_START_RJ = 6'h08;
   localparam logic [5:0] SAP_CNT_MAX = 6'h3f;

   // Per-input route codes
   localparam logic [1:0] SAP_ROUTE_SYNC = 2'h0;
   localparam logic [1:0] SAP_ROUTE_SIX = 2'h1;
   localparam logic [1:0] SAP_ROUTE_ST = 2'h2;
   localparam logic [1:0] SAP_ROUTE_OFF = 2'h3;
   localparam logic [7:0] SAP_ROUTE_DEF = 8'h00;

   // S/PDIF mux: 0 internal stream, 1..7 external pins
   localparam logic [2:0] SAP_SPDIF_INT = 3'h0;

   typedef enum logic [1:0] {
      SAP_ST_FILL = 2'b00,
      SAP_ST_SAMPLE = 2'b01,
      SAP_ST_DONE = 2'b10
   } sap_strap_t;
endpackage

// File: sap_serial_port.sv
// Functional notes
// - An input routed to either rate converter leaves the synchronous path and reaches the core only through that converter.
// - The synchronous input format comes from bits 3..2 of port control register 1.
// - Inputs routed to the rate converters take their format from bits 12..9 of that register.
// - The synchronous path may use any of the three clock pairs and defaults to pair 1.
// - The six-channel converter defaults to pair 0 and the stereo converter to pair 2, both reassignable.
// - An unused fourth data input serves as external S/PDIF input 0 to the output mux.
// - The six clock pins serve, when unused, as external S/PDIF inputs 1 to 6 in pin order.
// - A selected external S/PDIF input is passed to the output pin unchanged.
// - The serial output carries two channels in a format chosen by port control register 1.
// - The serial output always uses the synchronous path's clock pair.
// - After reset the output pin is sampled as an address strap on four consecutive master clocks.
// - The address select bit is the majority of those four samples.
// - The S/PDIF mux picks the internal stream or one of the external input pins.
`timescale 1ns/1ps
`default_nettype none
module sap_serial_port
   import sap_pkg::*;
#(
   parameter int WORD_W = SAP_WORD_W,
   parameter int FIFO_DEPTH = SAP_FIFO_DEPTH
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic serial_in_a_i,
   input wire logic serial_in_b_i,
   input wire logic serial_in_c_i,
   input wire logic serial_in_d_i,
   input wire logic frame_clk_pair0_i,
   input wire logic bit_clk_pair0_i,
   input wire logic frame_clk_pair1_i,
   input wire logic bit_clk_pair1_i,
   input wire logic frame_clk_pair2_i,
   input wire logic bit_clk_pair2_i,
   input wire logic serial_out_main_i,
   output logic serial_out_main_o,
   output logic serial_out_main_oe_o,
   input wire logic [15:0] port_ctrl1_i,
   input wire logic cfg_load_i,
   input wire logic [1:0] cfg_sync_pair_i,
   input wire logic [1:0] cfg_six_pair_i,
   input wire logic [1:0] cfg_st_pair_i,
   input wire logic [7:0] cfg_route_i,
   input wire logic [2:0] cfg_spdif_sel_i,
   input wire logic spdif_int_i,
   output logic spdif_out_o,
   output logic [SAP_INPUTS*WORD_W-1:0] rx_data_o,
   output logic rx_chan_o,
   output logic [SAP_INPUTS-1:0] rx_mask_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic rx_overrun_o,
   input wire logic [WORD_W-1:0] tx_left_i,
   input wire logic [WORD_W-1:0] tx_right_i,
   output logic tx_take_o,
   output logic [SAP_INPUTS-1:0] six_sdata_o,
   output logic six_frame_o,
   output logic six_bit_o,
   output logic [SAP_INPUTS-1:0] st_sdata_o,
   output logic st_frame_o,
   output logic st_bit_o,
   output logic [3:0] conv_fmt_o,
   output logic [1:0] sync_pair_o,
   output logic addr_strap_o,
   output logic strap_done_o
);
   localparam int NPIN = 11;
   localparam int FW = SAP_INPUTS*WORD_W + 1 + SAP_INPUTS;

   // Pins: [5:0] frame/bit clocks in pin order, [9:6] data a..d, [10] strap
   logic [NPIN-1:0] pin_raw, s1_r, s2_r;
   assign pin_raw = {serial_out_main_i, serial_in_d_i, serial_in_c_i, serial_in_b_i,
                     serial_in_a_i, bit_clk_pair2_i, frame_clk_pair2_i, bit_clk_pair1_i,
                     frame_clk_pair1_i, bit_clk_pair0_i, frame_clk_pair0_i};
   // No reset: the edge finder must start from the pins' real idle level,
   // or an idle-high bit clock shows a false rise right after reset
   always_ff @(posedge ref_clk_i) begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
   end
   logic [5:0] clk_s;
   logic [SAP_INPUTS-1:0] din_s;
   logic [6:0] ext_s;
   assign clk_s = s2_r[5:0];
   assign din_s = s2_r[9:6];
   assign ext_s = {clk_s, din_s[3]};

   // Configuration state
   logic [1:0] sync_pair_r, sync_pair_nxt, six_pair_r, six_pair_nxt, st_pair_r, st_pair_nxt;
   logic [7:0] route_r, route_nxt;
   logic [2:0] spdif_sel_r, spdif_sel_nxt;
   logic [SAP_INPUTS-1:0] sync_mask, six_mask, st_mask;
   always_comb begin
      sync_pair_nxt = sync_pair_r;
      six_pair_nxt = six_pair_r;
      st_pair_nxt = st_pair_r;
      route_nxt = route_r;
      spdif_sel_nxt = spdif_sel_r;
      if (cfg_load_i) begin
         // Pair code 3 does not exist; such a load leaves the selection alone
         if (cfg_sync_pair_i != SAP_PAIR_BAD) sync_pair_nxt = cfg_sync_pair_i;
         if (cfg_six_pair_i != SAP_PAIR_BAD) six_pair_nxt = cfg_six_pair_i;
         if (cfg_st_pair_i != SAP_PAIR_BAD) st_pair_nxt = cfg_st_pair_i;
         route_nxt = cfg_route_i;
         spdif_sel_nxt = cfg_spdif_sel_i;
      end
      for (int i = 0; i < SAP_INPUTS; i++) begin
         sync_mask[i] = (route_r[2*i +: 2] == SAP_ROUTE_SYNC);
         six_mask[i] = (route_r[2*i +: 2] == SAP_ROUTE_SIX);
         st_mask[i] = (route_r[2*i +: 2] == SAP_ROUTE_ST);
      end
   end

   // Selected serial clocks of the synchronous path, shared with the output
   logic lr, bc, bc_prev_r, lr_prev_r, seen_r, rise, fall;
   logic [1:0] fmt;
   logic [5:0] start, cnt_r, cnt_nxt, pos, off;
   assign lr = clk_s[2*sync_pair_r];
   assign bc = clk_s[2*sync_pair_r+1];
   assign rise = bc && !bc_prev_r;
   assign fall = !bc && bc_prev_r;
   assign fmt = port_ctrl1_i[SAP_SYNC_FMT_MSB:SAP_SYNC_FMT_LSB];
   always_comb begin
      unique case (fmt)
         SAP_FMT_LJ: start = SAP_START_LJ;
         SAP_FMT_RJ: start = SAP_START_RJ;
         default: start = SAP_START_I2S; // Code 3 is taken as I2S
      endcase
   end

   // Receive
   logic [WORD_W-1:0] sh_r [SAP_INPUTS];
   logic [WORD_W-1:0] sh_nxt [SAP_INPUTS];
   logic seen_nxt, push, fifo_ready, overrun_nxt, overrun_r;
   logic [FW-1:0] push_word;
   logic in_win;
   always_comb begin
      cnt_nxt = cnt_r;
      seen_nxt = seen_r;
      push = 1'b0;
      sh_nxt = sh_r;
      pos = cnt_r;
      if (rise) begin
         if (lr != lr_prev_r) begin
            pos = '0;
            push = seen_r;
            seen_nxt = 1'b1;
         end else if (cnt_r != SAP_CNT_MAX) begin
            pos = cnt_r + 1'b1;
         end
         cnt_nxt = pos;
      end
      in_win = ({1'b0, pos} >= {1'b0, start}) &&
               ({1'b0, pos} < ({1'b0, start} + 7'(WORD_W)));
      if (rise && in_win) begin
         for (int i = 0; i < SAP_INPUTS; i++) begin
            sh_nxt[i] = {sh_r[i][WORD_W-2:0], din_s[i]};
         end
      end
      for (int i = 0; i < SAP_INPUTS; i++) begin
         push_word[i*WORD_W +: WORD_W] = sync_mask[i] ? sh_r[i] : '0;
      end
      push_word[SAP_INPUTS*WORD_W] = lr_prev_r;
      push_word[FW-1 -: SAP_INPUTS] = sync_mask;
      // The serial link cannot be stalled; a full FIFO drops the word
      overrun_nxt = overrun_r || (push && !fifo_ready);
   end

   logic [FW-1:0] fifo_out;
   sap_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(push),
      .in_ready_o(fifo_ready),
      .in_data_i(push_word),
      .out_valid_o(rx_valid_o),
      .out_ready_i(rx_ready_i),
      .out_data_o(fifo_out)
   );
   assign rx_data_o = fifo_out[SAP_INPUTS*WORD_W-1:0];
   assign rx_chan_o = fifo_out[SAP_INPUTS*WORD_W];
   assign rx_mask_o = fifo_out[FW-1 -: SAP_INPUTS];

   // Transmit: bits change on falling edges so the far end samples on rising ones
   logic [WORD_W-1:0] txl_r, txl_nxt, txr_r, txr_nxt;
   logic sdo_r, sdo_nxt, take_nxt, tx_win;
   logic [5:0] tpos;
   always_comb begin
      txl_nxt = txl_r;
      txr_nxt = txr_r;
      sdo_nxt = sdo_r;
      take_nxt = 1'b0;
      tpos = (lr != lr_prev_r) ? '0 : ((cnt_r == SAP_CNT_MAX) ? cnt_r : cnt_r + 1'b1);
      off = tpos - start;
      tx_win = (tpos >= start) && ({1'b0, tpos} < ({1'b0, start} + 7'(WORD_W)));
      if (fall) begin
         if (lr != lr_prev_r && !lr) begin
            txl_nxt = tx_left_i;
            txr_nxt = tx_right_i;
            take_nxt = 1'b1;
         end
         if (!tx_win) begin
            sdo_nxt = 1'b0;
         end else if (lr) begin
            sdo_nxt = txr_r[WORD_W-1-int'(off)];
         end else begin
            sdo_nxt = (lr != lr_prev_r) ? tx_left_i[WORD_W-1-int'(off)]
                                        : txl_r[WORD_W-1-int'(off)];
         end
      end
   end

   // Address strap: wait for the synchronisers to fill, then take four samples
   sap_strap_t st_r, st_nxt;
   logic [2:0] scnt_r, scnt_nxt, ones_r, ones_nxt;
   logic addr_r, addr_nxt;
   always_comb begin
      st_nxt = st_r;
      scnt_nxt = scnt_r;
      ones_nxt = ones_r;
      addr_nxt = addr_r;
      unique case (st_r)
         SAP_ST_FILL: begin
            scnt_nxt = scnt_r + 1'b1;
            if (scnt_r == 3'(SAP_SYNC_STAGES)) begin
               st_nxt = SAP_ST_SAMPLE;
               scnt_nxt = '0;
            end
         end
         SAP_ST_SAMPLE: begin
            ones_nxt = ones_r + {2'b00, s2_r[10]};
            scnt_nxt = scnt_r + 1'b1;
            if (scnt_r == 3'(SAP_STRAP_SAMPLES-1)) begin
               st_nxt = SAP_ST_DONE;
               // Strictly more than half; a tie resolves low
               addr_nxt = (ones_nxt > 3'(SAP_STRAP_SAMPLES/2));
            end
         end
         SAP_ST_DONE: begin
         end
         default: st_nxt = SAP_ST_FILL;
      endcase
   end

   logic spdif_nxt;
   assign spdif_nxt = (spdif_sel_r == SAP_SPDIF_INT) ? spdif_int_i
                                                    : ext_s[spdif_sel_r - 3'h1];

   always_ff @(posedge ref_clk_i) begin
      bc_prev_r <= bc;
      if (!resetn_i) begin
         sync_pair_r <= SAP_PAIR_SYNC_DEF;
         six_pair_r <= SAP_PAIR_SIX_DEF;
         st_pair_r <= SAP_PAIR_ST_DEF;
         route_r <= SAP_ROUTE_DEF;
         spdif_sel_r <= SAP_SPDIF_INT;
         lr_prev_r <= 1'b0;
         seen_r <= 1'b0;
         cnt_r <= '0;
         overrun_r <= 1'b0;
         txl_r <= '0;
         txr_r <= '0;
         sdo_r <= 1'b0;
         tx_take_o <= 1'b0;
         st_r <= SAP_ST_FILL;
         scnt_r <= '0;
         ones_r <= '0;
         addr_r <= 1'b0;
         spdif_out_o <= 1'b0;
         six_sdata_o <= '0;
         st_sdata_o <= '0;
         six_frame_o <= 1'b0;
         six_bit_o <= 1'b0;
         st_frame_o <= 1'b0;
         st_bit_o <= 1'b0;
         conv_fmt_o <= '0;
         for (int i = 0; i < SAP_INPUTS; i++) sh_r[i] <= '0;
      end else begin
         sync_pair_r <= sync_pair_nxt;
         six_pair_r <= six_pair_nxt;
         st_pair_r <= st_pair_nxt;
         route_r <= route_nxt;
         spdif_sel_r <= spdif_sel_nxt;
         if (rise) lr_prev_r <= lr;
         seen_r <= seen_nxt;
         cnt_r <= cnt_nxt;
         overrun_r <= overrun_nxt;
         txl_r <= txl_nxt;
         txr_r <= txr_nxt;
         sdo_r <= sdo_nxt;
         tx_take_o <= take_nxt;
         st_r <= st_nxt;
         scnt_r <= scnt_nxt;
         ones_r <= ones_nxt;
         addr_r <= addr_nxt;
         spdif_out_o <= spdif_nxt;
         six_sdata_o <= din_s & six_mask;
         st_sdata_o <= din_s & st_mask;
         six_frame_o <= clk_s[2*six_pair_r];
         six_bit_o <= clk_s[2*six_pair_r+1];
         st_frame_o <= clk_s[2*st_pair_r];
         st_bit_o <= clk_s[2*st_pair_r+1];
         conv_fmt_o <= port_ctrl1_i[SAP_CONV_FMT_MSB:SAP_CONV_FMT_LSB];
         sh_r <= sh_nxt;
      end
   end

   assign serial_out_main_o = sdo_r;
   assign serial_out_main_oe_o = (st_r == SAP_ST_DONE);
   assign strap_done_o = (st_r == SAP_ST_DONE);
   assign addr_strap_o = addr_r;
   assign rx_overrun_o = overrun_r;
   assign sync_pair_o = sync_pair_r;

   sequence strap_fill_s;
      st_r == SAP_ST_FILL [*3];
   endsequence
   sequence strap_sample_s;
      st_r == SAP_ST_SAMPLE [*4] ##1 st_r == SAP_ST_DONE;
   endsequence

   strap_hold_a: assert property (@(posedge ref_clk_i)
      $rose(resetn_i) |-> !serial_out_main_oe_o [*6])
      else $error("output driven during strap window");
   strap_samples_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $rose(st_r == SAP_ST_SAMPLE) |-> strap_sample_s)
      else $error("strap not sampled for four cycles");
   strap_start_a: assert property (@(posedge ref_clk_i)
      $rose(resetn_i) |-> strap_fill_s ##1 strap_sample_s)
      else $error("strap sampling not started after fill");
   strap_major_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $rose(strap_done_o) |-> addr_strap_o == (ones_r >= 3'h3))
      else $error("strap bit is not the majority");
   strap_tie_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (strap_done_o && ones_r == 3'h2) |-> !addr_strap_o)
      else $error("tied strap not resolved low");
   pair_default_a: assert property (@(posedge ref_clk_i)
      $rose(resetn_i) |-> sync_pair_r == SAP_PAIR_SYNC_DEF &&
         six_pair_r == SAP_PAIR_SIX_DEF && st_pair_r == SAP_PAIR_ST_DEF)
      else $error("clock pair defaults wrong");
   route_excl_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      push |-> (push_word[FW-1 -: SAP_INPUTS] & (six_mask | st_mask)) == '0 ##1
         (six_sdata_o & ~$past(six_mask)) == '0)
      else $error("routed input reached the synchronous path");
   spdif_pass_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (spdif_sel_r != SAP_SPDIF_INT && $stable(spdif_sel_r)) |=>
         spdif_out_o == $past(ext_s[spdif_sel_r - 3'h1]))
      else $error("external S/PDIF not passed through");
   out_pair_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      rise |-> bc == clk_s[2*sync_pair_r+1] && lr == clk_s[2*sync_pair_r])
      else $error("output not on synchronous clock pair");
endmodule
`default_nettype wire

// File: sap_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sap_serial_port_tb
   import sap_pkg::*;
   ;
   logic clk, rstn, load, sp_int, rdy, rdy_hold, rnd_en, strap_lvl, ovr_en;
   logic [15:0] ctrl;
   logic [1:0] c_sync, c_six, c_st, pair;
   logic [7:0] route;
   logic [2:0] sel;
   logic [6:0] ovr;
   logic [23:0] tx_l, tx_r;
   logic [5:0] cp;
   logic [3:0] sd;
   logic [100:0] exp_q[$];
   int err_total, checks, takes;
   int cyc = 0;
   integer seed;
   wire logic pf, pb, so, oe, sp_out, chan, vld, ovf, s6f, s6b, stf, stb, strap, done, take;
   wire logic [3:0] pd, mask, cfmt, sd6, sdst;
   wire logic [1:0] spair;
   wire logic [SAP_INPUTS*SAP_WORD_W-1:0] data;
   // Board level of the shared pin: device when enabled, otherwise the strap driver
   wire logic pin = oe ? so : strap_lvl;

   always_comb begin
      // Unused clock pins idle high like the partner's, so a pair switch shows no edge
      cp = 6'h3f;
      cp[2*pair] = pf;
      cp[2*pair+1] = pb;
      sd = pd;
      if (ovr_en) begin
         cp = ovr[6:1];
         sd[3] = ovr[0];
      end
   end

   sap_serial_port u_dut (
      .ref_clk_i(clk), .resetn_i(rstn),
      .serial_in_a_i(sd[0]), .serial_in_b_i(sd[1]), .serial_in_c_i(sd[2]), .serial_in_d_i(sd[3]),
      .frame_clk_pair0_i(cp[0]), .bit_clk_pair0_i(cp[1]), .frame_clk_pair1_i(cp[2]),
      .bit_clk_pair1_i(cp[3]), .frame_clk_pair2_i(cp[4]), .bit_clk_pair2_i(cp[5]),
      .serial_out_main_i(pin), .serial_out_main_o(so), .serial_out_main_oe_o(oe),
      .port_ctrl1_i(ctrl), .cfg_load_i(load), .cfg_sync_pair_i(c_sync), .cfg_six_pair_i(c_six),
      .cfg_st_pair_i(c_st), .cfg_route_i(route), .cfg_spdif_sel_i(sel), .spdif_int_i(sp_int),
      .spdif_out_o(sp_out), .rx_data_o(data), .rx_chan_o(chan), .rx_mask_o(mask),
      .rx_valid_o(vld), .rx_ready_i(rdy), .rx_overrun_o(ovf), .tx_left_i(tx_l),
      .tx_right_i(tx_r), .tx_take_o(take), .six_sdata_o(sd6), .six_frame_o(s6f), .six_bit_o(s6b),
      .st_sdata_o(sdst), .st_frame_o(stf), .st_bit_o(stb), .conv_fmt_o(cfmt),
      .sync_pair_o(spair), .addr_strap_o(strap), .strap_done_o(done)
   );

   sap_partner u_partner (.sdo_i(pin), .frame_o(pf), .bit_o(pb), .sdata_o(pd));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input string what, input logic [100:0] exp, input logic [100:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (take === 1'b1) takes++;
      if (cyc == 9000) begin
         err_total++;
         wrap_up();
      end
   end

   always @(posedge clk) begin
      #2;
      rdy = rnd_en ? 1'($random(seed)) : rdy_hold;
   end

   // Handshake is judged on pre-edge values, the same ones the FIFO sees
   always @(posedge clk) begin
      if (rstn && vld === 1'b1 && rdy) begin
         if (exp_q.size() == 0) chk("rx_extra", 0, 1);
         else chk("rx_word", exp_q.pop_front(), {chan, mask, data});
      end
   end

   task automatic do_reset(input logic [1:0] mode);
      int n;
      rstn = 1'b0;
      strap_lvl = mode[0];
      repeat (4) @(posedge clk);
      #2;
      chk("pair_rst", SAP_PAIR_SYNC_DEF, spair);
      rstn = 1'b1;
      // Alternating level gives a two-two split whatever sampling offset is used
      for (n = 1; n < 12 && done !== 1'b1; n++) begin
         @(posedge clk);
         #2;
         if (mode == 2'h2) strap_lvl = ~strap_lvl;
         if (done !== 1'b1) chk("oe_strap", 0, oe);
      end
      chk("strap_cycles", 8, n);
      chk("strap", mode == 2'h1, strap);
      chk("oe_on", 1, oe);
   endtask

   task automatic pulse();
      load = 1'b1;
      @(posedge clk);
      #2 load = 1'b0;
      repeat (2) @(posedge clk);
      #2;
   endtask

   task automatic run(input logic [1:0] mode, input logic [1:0] fmt, input logic [1:0] sp,
                      input logic [7:0] rt, input logic [3:0] msk, input int halves, keep);
      logic [23:0] w [4];
      logic [23:0] cap;
      logic [95:0] d;
      int h, i, start;
      logic [3:0] m6, mst;
      do_reset(mode);
      takes = 0;
      ctrl = (16'($random(seed)) & 16'hfff3) | {12'h000, fmt, 2'h0};
      tx_l = 24'($random(seed));
      tx_r = 24'($random(seed));
      route = rt;
      if (sp != 2'h1) begin
         {c_sync, c_six, c_st} = 6'h3f;
         pulse();
         chk("pair_refused", 2'h1, spair);
         c_sync = sp;
         c_six = sp ^ 2'h2;
         c_st = 2'h1;
         pulse();
         chk("pair_load", sp, spair);
      end
      repeat (3) @(posedge clk);
      #2;
      chk("conv_fmt", ctrl[12:9], cfmt);
      pair = sp;
      rnd_en = (keep < 8);
      rdy_hold = 1'b0;
      start = fmt == SAP_FMT_LJ ? 0 : fmt == SAP_FMT_RJ ? 8 : 1;
      for (h = 0; h < halves; h++) begin
         for (i = 0; i < 4; i++) w[i] = 24'($random(seed));
         u_partner.send_half(w, h[0], start, cap);
         if (h >= 2) chk("tx_word", h[0] ? tx_r : tx_l, cap);
         if (h >= 1 && h <= keep) begin
            for (i = 0; i < 4; i++) d[i*24 +: 24] = msk[i] ? w[i] : 24'h00_0000;
            exp_q.push_back({h[0], msk, d});
         end
      end
      // A stalled run overflows the 8-deep FIFO; later words must be dropped
      chk("overrun", keep == 8, ovf);
      rnd_en = 1'b0;
      rdy_hold = 1'b1;
      repeat (40) @(posedge clk);
      #2;
      chk("rx_left", 0, exp_q.size());
      chk("rx_drained", 0, vld);
      for (i = 0; i < 4; i++) begin
         m6[i] = (rt[2*i +: 2] == 2'h1);
         mst[i] = (rt[2*i +: 2] == 2'h2);
      end
      chk("six_data", pd & m6, sd6);
      chk("st_data", pd & mst, sdst);
      // The first left half after reset is not framed, so it latches no words
      chk("tx_take", halves / 2 - 1, takes);
   endtask

   initial begin
      int s, k;
      seed = 32'h2a6d_f2ea;
      {rstn, load, sp_int, rdy, rdy_hold, rnd_en, strap_lvl, ovr_en} = '0;
      {ctrl, route, sel, ovr} = '0;
      {c_sync, c_six, c_st} = 6'h3f;
      pair = 2'h1;
      tx_l = '0;
      tx_r = '0;
      err_total = 0;
      checks = 0;
      do_reset(2'h1);
      // Load stays high so each selection is taken; pair code 3 keeps the defaults
      {ovr_en, load} = 2'b11;
      for (s = 0; s < 8; s++) begin
         for (k = 0; k < 3; k++) begin
            sel = s[2:0];
            ovr = 7'($random(seed));
            sp_int = 1'($random(seed));
            repeat (4) @(posedge clk);
            #2;
            chk("spdif_out", s == 0 ? sp_int : ovr[s-1], sp_out);
         end
      end
      chk("conv_clks", {ovr[1], ovr[2], ovr[5], ovr[6]}, {s6f, s6b, stf, stb});
      {ovr_en, load} = 2'b00;
      run(2'h0, SAP_FMT_I2S, 2'h1, 8'h00, 4'hf, 6, 4);
      run(2'h2, SAP_FMT_LJ, 2'h2, 8'h24, 4'h9, 6, 4);
      run(2'h1, SAP_FMT_RJ, 2'h0, 8'hc0, 4'h7, 12, 8);
      wrap_up();
   end
endmodule
`default_nettype wire
